// ### rtl/sfb_front_end.sv
// Serial flash bus front end: lane widening, four-wire mode, pause and clear.
// Assumes a bus master drives the bus clock at well below a quarter of the core
// clock and that a command layer supplies read data and the quad enable bit.
//
// How it works
// - Works with bus masters using clock mode 0 or mode 3.
// - Input lanes sampled on bus clock rising edges, outputs launched on falling.
// - Dual output read 3BH sends on lanes 0 and 1; dual I/O read BBH uses them both ways, two bits per clock.
// - Quad read commands use four lanes, write protect and pause become lanes 2, 3.
// - Quad lane commands accepted only while quad enable bit is 1.
// - Enable code puts device in four wire mode, commands then use four lanes.
// - Serial and four wire modes exclusive; 38H enters, FFH leaves.
// - After power-up and software reset 99H the device is in serial mode.
// - Four wire mode allowed only while quad enable bit is 1.
// - Pause works only with quad enable 0; otherwise pause pin is lane 3.
// - Pause stalls serial transfer only; internal write, program, erase continue.
// - Pause begins on pause low with clock low, else when clock next low.
// - Pause ends on pause high with clock low, else when clock next low.
// - While paused, output lane floats; input lane and bus clock ignored.
// - Deselect during pause resets interface logic, abandoning the transaction.
// - Array: 256-byte pages, 4K sectors, 32K/64K blocks, sector n at n*4096.
// - Clear pin low at least 1 us returns volatile state to power-on values.
`timescale 1ns/1ps
`default_nettype none
module sfb_front_end (
  input  wire logic        ref_clk_in,          // Core clock, 50 MHz
  input  wire logic        srst_in,             // Synchronous reset, active high
  input  wire logic        bus_clock_in,        // Bus clock pin
  input  wire logic        select_n_in,         // Select pin, active low
  input  wire logic        hard_clear_n_in,     // Hardware clear pin, active low
  input  wire logic [3:0]  lane_in,             // Lane pin levels 3..0
  output logic      [3:0]  lane_out,            // Lane drive values
  output logic      [3:0]  lane_oe_out,         // Lane drive enables, high drives
  input  wire logic        quad_enable_bit_in,  // Non-volatile quad enable
  input  wire logic        tx_en_in,            // Command layer: drive read data
  input  wire logic [7:0]  tx_data_in,          // Next byte to send
  output logic             tx_take_out,         // Pulse: tx_data_in consumed
  output logic [7:0]       rx_byte_out,         // Last received byte
  output logic             rx_valid_out,        // Pulse: rx_byte_out new
  output logic             rx_cmd_out,          // rx_byte_out is a command byte
  output logic             cmd_reject_out,      // Pulse: quad command refused
  output logic             qpi_mode_out,        // Four wire mode active
  output logic             paused_out,          // Pause in effect
  output logic [23:0]      addr_out,            // Address of current frame
  output logic [11:0]      sector_out,          // Sector index of addr_out
  output logic [7:0]       block64_out          // 64K block index of addr_out
);
  // ************************************************************
  // Pin synchronisation and edge detection
  // ************************************************************
  logic [sfb_pkg::SY_W-1:0] sy;
  logic                     clk_d;
  logic                     rise;
  logic                     fall;
  logic                     sel_n_s;
  logic                     hclr_n_s;
  sfb_pause_if              pif ();

  // Select idles high; a master that lets it float breaks this
  sfb_sync #(
    .W    (sfb_pkg::SY_W),
    .INIT (sfb_pkg::SY_INIT)
  ) u_sync (
    .clk_in (ref_clk_in),
    .rst_in (srst_in),
    .d_in   ({hard_clear_n_in, select_n_in, bus_clock_in, lane_in}),
    .q_out  (sy)
  );

  assign sel_n_s  = sy[sfb_pkg::SY_SEL];
  assign hclr_n_s = sy[sfb_pkg::SY_CLR];
  // Only edges inside a frame count, so mode 0 and mode 3 idle levels are alike
  assign rise = sy[sfb_pkg::SY_CLK] && !clk_d && !sel_n_s;
  assign fall = !sy[sfb_pkg::SY_CLK] && clk_d && !sel_n_s;

  assign pif.bus_clk  = sy[sfb_pkg::SY_CLK];
  assign pif.select_n = sel_n_s;
  assign pif.pause_n  = sy[3];
  assign pif.qe       = quad_enable_bit_in;

  sfb_pause u_pause (
    .clk_in (ref_clk_in),
    .rst_in (srst_in),
    .pif    (pif)
  );

  // ************************************************************
  // Engine state
  // ************************************************************
  logic [3:0]  rx_cnt,  next_rx_cnt;
  logic [7:0]  rx_shift, next_rx_shift;
  logic [2:0]  idx,     next_idx;
  logic [2:0]  rx_w,    next_rx_w;
  logic [2:0]  tx_w,    next_tx_w;
  logic [2:0]  tx_cnt,  next_tx_cnt;
  logic [7:0]  tx_shift, next_tx_shift;
  logic        armed,   next_armed;
  logic [5:0]  clr_cnt, next_clr_cnt;
  logic [3:0]  next_lane, next_oe;
  logic [7:0]  next_rx_byte;
  logic        next_rx_valid, next_rx_cmd, next_take, next_reject, next_qpi;
  logic [23:0] next_addr;
  logic [7:0]  shifted;
  logic [7:0]  tx_src;
  logic        byte_done;
  logic        cmd_done;
  logic        clear_hit;

  assign clear_hit = !hclr_n_s && (clr_cnt == 6'(sfb_pkg::CLEAR_CYC - 1));
  assign tx_src    = (tx_cnt == 3'h0) ? tx_data_in : tx_shift;

  always_comb
  begin
    unique case (rx_w)
      sfb_pkg::W2: shifted = {rx_shift[5:0], sy[1:0]};
      sfb_pkg::W4: shifted = {rx_shift[3:0], sy[3:0]};
      default:     shifted = {rx_shift[6:0], sy[0]};
    endcase
  end

  assign byte_done = rise && !pif.paused && (rx_cnt + 4'(rx_w) == sfb_pkg::BYTE_BITS);
  assign cmd_done  = byte_done && (idx == 3'h0) && !clear_hit;

  always_comb
  begin
    next_rx_cnt   = rx_cnt;
    next_rx_shift = rx_shift;
    next_idx      = idx;
    next_rx_w     = rx_w;
    next_tx_w     = tx_w;
    next_tx_cnt   = tx_cnt;
    next_tx_shift = tx_shift;
    next_armed    = armed;
    next_lane     = lane_out;
    next_oe       = lane_oe_out;
    next_rx_byte  = rx_byte_out;
    next_rx_cmd   = rx_cmd_out;
    next_rx_valid = 1'b0;
    next_take     = 1'b0;
    next_reject   = 1'b0;
    next_qpi      = qpi_mode_out;
    next_addr     = addr_out;
    next_clr_cnt  = hclr_n_s ? 6'h00 : (clear_hit ? clr_cnt : clr_cnt + 6'h01);

    // Pause gates only this engine; array work behind it is not stalled
    if (rise && !pif.paused)
    begin
      next_rx_shift = shifted;
      next_rx_cnt   = rx_cnt + 4'(rx_w);
      if (byte_done)
      begin
        next_rx_cnt   = 4'h0;
        next_rx_byte  = shifted;
        next_rx_valid = 1'b1;
        next_rx_cmd   = (idx == 3'h0);
        if (idx != 3'h7)
          next_idx = idx + 3'h1;
        if (idx != 3'h0 && idx <= sfb_pkg::ADDR_LAST_IDX)
          next_addr = {addr_out[15:0], shifted};
      end
    end
    if (cmd_done)
    begin
      next_armed = (shifted == sfb_pkg::CMD_RST_EN);
      if (armed && shifted == sfb_pkg::CMD_RST)
        next_qpi = 1'b0;
      else if (qpi_mode_out)
      begin
        if (shifted == sfb_pkg::CMD_QPI_OFF)
          next_qpi = 1'b0;
      end
      else
        unique case (shifted)
          sfb_pkg::CMD_QPI_ON:
            if (quad_enable_bit_in)
              next_qpi = 1'b1;
            else
              next_reject = 1'b1;
          sfb_pkg::CMD_DUAL_OUT:
            next_tx_w = sfb_pkg::W2;
          sfb_pkg::CMD_DUAL_IO:
          begin
            next_rx_w = sfb_pkg::W2;
            next_tx_w = sfb_pkg::W2;
          end
          sfb_pkg::CMD_QUAD_OUT:
            if (quad_enable_bit_in)
              next_tx_w = sfb_pkg::W4;
            else
              next_reject = 1'b1;
          sfb_pkg::CMD_QUAD_IO:
            if (quad_enable_bit_in)
            begin
              next_rx_w = sfb_pkg::W4;
              next_tx_w = sfb_pkg::W4;
            end
            else
              next_reject = 1'b1;
          default:
            next_reject = 1'b0;
        endcase
    end

    if (fall && !pif.paused)
    begin
      if (tx_en_in)
      begin
        next_take     = (tx_cnt == 3'h0);
        next_tx_shift = tx_src << tx_w;
        next_tx_cnt   = tx_cnt + tx_w;
        unique case (tx_w)
          sfb_pkg::W2:
          begin
            next_lane = {2'b00, tx_src[7:6]};
            next_oe   = sfb_pkg::OE_W2;
          end
          sfb_pkg::W4:
          begin
            next_lane = tx_src[7:4];
            next_oe   = sfb_pkg::OE_W4;
          end
          default:
          begin
            next_lane = {2'b00, tx_src[7], 1'b0};
            next_oe   = sfb_pkg::OE_W1;
          end
        endcase
      end
      else
        next_oe = 4'h0;
    end

    if (pif.paused)
      next_oe = 4'h0;
    if (clear_hit)
    begin
      next_qpi   = 1'b0;
      next_armed = 1'b0;
    end
    if (!quad_enable_bit_in)
      next_qpi = 1'b0;
    // Deselect, abandoned pause or clear all end the frame
    if (sel_n_s || pif.abandon || clear_hit)
    begin
      next_rx_cnt = 4'h0;
      next_idx    = 3'h0;
      next_tx_cnt = 3'h0;
      next_oe     = 4'h0;
      next_rx_w   = next_qpi ? sfb_pkg::W4 : sfb_pkg::W1;
      next_tx_w   = next_qpi ? sfb_pkg::W4 : sfb_pkg::W1;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      clk_d          <= 1'b0;
      rx_cnt         <= 4'h0;
      rx_shift       <= 8'h00;
      idx            <= 3'h0;
      rx_w           <= sfb_pkg::W1;
      tx_w           <= sfb_pkg::W1;
      tx_cnt         <= 3'h0;
      tx_shift       <= 8'h00;
      armed          <= 1'b0;
      clr_cnt        <= 6'h00;
      lane_out       <= 4'h0;
      lane_oe_out    <= 4'h0;
      rx_byte_out    <= 8'h00;
      rx_valid_out   <= 1'b0;
      rx_cmd_out     <= 1'b0;
      tx_take_out    <= 1'b0;
      cmd_reject_out <= 1'b0;
      qpi_mode_out   <= 1'b0;
      paused_out     <= 1'b0;
      addr_out       <= 24'h000000;
      sector_out     <= 12'h000;
      block64_out    <= 8'h00;
    end
    else
    begin
      clk_d          <= sy[sfb_pkg::SY_CLK];
      rx_cnt         <= next_rx_cnt;
      rx_shift       <= next_rx_shift;
      idx            <= next_idx;
      rx_w           <= next_rx_w;
      tx_w           <= next_tx_w;
      tx_cnt         <= next_tx_cnt;
      tx_shift       <= next_tx_shift;
      armed          <= next_armed;
      clr_cnt        <= next_clr_cnt;
      lane_out       <= next_lane;
      lane_oe_out    <= next_oe;
      rx_byte_out    <= next_rx_byte;
      rx_valid_out   <= next_rx_valid;
      rx_cmd_out     <= next_rx_cmd;
      tx_take_out    <= next_take;
      cmd_reject_out <= next_reject;
      qpi_mode_out   <= next_qpi;
      paused_out     <= pif.paused;
      addr_out       <= next_addr;
      sector_out     <= next_addr[sfb_pkg::ADDR_W-1:sfb_pkg::SECTOR_LSB];
      block64_out    <= next_addr[sfb_pkg::ADDR_W-1:sfb_pkg::BLOCK64_LSB];
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  property p_qpi_needs_qe;
    !quad_enable_bit_in |=> !qpi_mode_out;
  endproperty
  a_qpi_needs_qe: assert property (p_qpi_needs_qe) else $error("four wire mode without qe");

  property p_qpi_enter;
    cmd_done && !qpi_mode_out && !armed && shifted == sfb_pkg::CMD_QPI_ON && quad_enable_bit_in
      |=> qpi_mode_out;
  endproperty
  a_qpi_enter: assert property (p_qpi_enter) else $error("enable code not taken");

  property p_qpi_exit;
    cmd_done && qpi_mode_out && shifted == sfb_pkg::CMD_QPI_OFF |=> !qpi_mode_out;
  endproperty
  a_qpi_exit: assert property (p_qpi_exit) else $error("disable code not taken");

  property p_sw_reset;
    cmd_done && armed && shifted == sfb_pkg::CMD_RST |=> !qpi_mode_out;
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("software reset left four wire mode");

  property p_quad_gate;
    cmd_done && !qpi_mode_out && !quad_enable_bit_in && !armed
      && (shifted == sfb_pkg::CMD_QUAD_IO || shifted == sfb_pkg::CMD_QUAD_OUT)
      |=> cmd_reject_out && tx_w != sfb_pkg::W4;
  endproperty
  a_quad_gate: assert property (p_quad_gate) else $error("quad command without qe");

  property p_dual_io;
    cmd_done && !qpi_mode_out && !armed && !sel_n_s && !pif.abandon
      && shifted == sfb_pkg::CMD_DUAL_IO |=> rx_w == sfb_pkg::W2 && tx_w == sfb_pkg::W2;
  endproperty
  a_dual_io: assert property (p_dual_io) else $error("dual io width not set");

  property p_pause_hiz;
    paused_out |-> lane_oe_out == 4'h0;
  endproperty
  a_pause_hiz: assert property (p_pause_hiz) else $error("lane driven in pause");

  property p_rx_on_rise;
    rx_valid_out |-> $past(rise) && !$past(pif.paused);
  endproperty
  a_rx_on_rise: assert property (p_rx_on_rise) else $error("byte not on rising edge");

  property p_tx_on_fall;
    $changed(lane_oe_out) && lane_oe_out != 4'h0 |-> $past(fall) && $past(tx_en_in);
  endproperty
  a_tx_on_fall: assert property (p_tx_on_fall) else $error("drive not on falling edge");

  property p_clear;
    clear_hit |=> !qpi_mode_out && lane_oe_out == 4'h0 && rx_cnt == 4'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not restore state");
endmodule // sfb_front_end
`default_nettype wire

// ### inc/sfb_pkg.sv
// Constants, command codes and types shared by the serial flash bus front end.
// Assumes a single 50 MHz core clock that samples every bus pin.
package sfb_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int CLEAR_MIN_NS  = 1000;
  // Least time, so round up to whole cycles
  localparam int CLEAR_CYC     = (CLEAR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ************************************************************
  // Command codes seen by the front end
  // ************************************************************
  localparam logic [7:0] CMD_DUAL_OUT = 8'h3B;
  localparam logic [7:0] CMD_DUAL_IO  = 8'hBB;
  localparam logic [7:0] CMD_QUAD_OUT = 8'h6B;
  localparam logic [7:0] CMD_QUAD_IO  = 8'hEB;
  localparam logic [7:0] CMD_QPI_ON   = 8'h38;
  localparam logic [7:0] CMD_QPI_OFF  = 8'hFF;
  localparam logic [7:0] CMD_RST_EN   = 8'h66;
  localparam logic [7:0] CMD_RST      = 8'h99;

  // ************************************************************
  // Lane widths (bits per bus clock) and matching output enables
  // ************************************************************
  localparam logic [2:0] W1    = 3'h1;
  localparam logic [2:0] W2    = 3'h2;
  localparam logic [2:0] W4    = 3'h4;
  localparam logic [3:0] OE_W1 = 4'h2;
  localparam logic [3:0] OE_W2 = 4'h3;
  localparam logic [3:0] OE_W4 = 4'hF;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ************************************************************
  // Array organisation
  // ************************************************************
  localparam int ADDR_W        = 24;
  localparam int PAGE_BYTES    = 256;
  localparam int SECTOR_BYTES  = 4096;
  localparam int BLOCK32_BYTES = 32768;
  localparam int BLOCK64_BYTES = 65536;
  localparam int PAGE_LSB      = $clog2(PAGE_BYTES);
  localparam int SECTOR_LSB    = $clog2(SECTOR_BYTES);
  localparam int BLOCK32_LSB   = $clog2(BLOCK32_BYTES);
  localparam int BLOCK64_LSB   = $clog2(BLOCK64_BYTES);
  localparam logic [2:0] ADDR_LAST_IDX = 3'h3;

  // ************************************************************
  // Synchroniser bit positions and idle values
  // ************************************************************
  localparam int SY_CLK   = 4;
  localparam int SY_SEL   = 5;
  localparam int SY_CLR   = 6;
  localparam int SY_W     = 7;
  localparam logic [6:0] SY_INIT = 7'h68;

  typedef enum logic {PS_RUN, PS_HOLD} sfb_pause_st_t;

endpackage

// ### inc/sfb_pause_if.sv
// Signals between the front end core and its pause qualifier.
// Assumes all members are synchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
interface sfb_pause_if;
  logic bus_clk;
  logic select_n;
  logic pause_n;
  logic qe;
  logic paused;
  logic abandon;
  modport ctl  (input bus_clk, select_n, pause_n, qe, output paused, abandon);
  modport core (output bus_clk, select_n, pause_n, qe, input paused, abandon);
endinterface
`default_nettype wire

// ### rtl/sfb_sync.sv
// Two flip-flop synchroniser for a group of pin levels.
// Assumes the inputs are asynchronous to clk_in; stage one feeds stage two only.
`timescale 1ns/1ps
`default_nettype none
module sfb_sync #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk_in,  // Core clock
  input  wire logic         rst_in,  // Synchronous reset
  input  wire logic [W-1:0] d_in,    // Asynchronous levels
  output logic      [W-1:0] q_out    // Synchronised levels
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      meta  <= INIT;
      q_out <= INIT;
    end
    else
    begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule // sfb_sync
`default_nettype wire

// ### rtl/sfb_pause.sv
// Pause qualifier: starts and ends a pause only while the bus clock is low, except that deselect or quad enable ends it at once.
// Assumes synchronised pin levels arrive through the interface.
`timescale 1ns/1ps
`default_nettype none
module sfb_pause (
  input  wire logic clk_in,  // Core clock
  input  wire logic rst_in,  // Synchronous reset
  sfb_pause_if.ctl  pif      // Pin levels in, pause state out
);
  sfb_pkg::sfb_pause_st_t state;
  sfb_pkg::sfb_pause_st_t next_state;
  logic                   abandon;
  logic                   next_abandon;

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  always_comb
  begin
    next_state   = state;
    next_abandon = 1'b0;
    unique case (state)
      sfb_pkg::PS_RUN:
        if (!pif.qe && !pif.select_n && !pif.pause_n && !pif.bus_clk)
          next_state = sfb_pkg::PS_HOLD;
      sfb_pkg::PS_HOLD:
        if (pif.select_n)
        begin
          next_state   = sfb_pkg::PS_RUN;
          next_abandon = 1'b1;
        end
        else if (pif.pause_n && !pif.bus_clk)
          next_state = sfb_pkg::PS_RUN;
    endcase
    // Quad enable turns the pin into a plain data lane
    if (pif.qe)
      next_state = sfb_pkg::PS_RUN;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state   <= sfb_pkg::PS_RUN;
      abandon <= 1'b0;
    end
    else
    begin
      state   <= next_state;
      abandon <= next_abandon;
    end
  end

  assign pif.paused  = (state == sfb_pkg::PS_HOLD);
  assign pif.abandon = abandon;

  property p_pause_start;
    !pif.paused && !pif.qe && !pif.select_n && !pif.pause_n && !pif.bus_clk |=> pif.paused;
  endproperty
  a_pause_start: assert property (p_pause_start) else $error("pause did not start");

  property p_pause_wait_low;
    !pif.paused && pif.bus_clk |=> !pif.paused;
  endproperty
  a_pause_wait_low: assert property (p_pause_wait_low) else $error("pause began, clock high");

  property p_pause_end;
    pif.paused && !pif.select_n && pif.bus_clk && !pif.qe |=> pif.paused;
  endproperty
  a_pause_end: assert property (p_pause_end) else $error("pause ended, clock high");

  property p_pause_qe;
    pif.qe |=> !pif.paused;
  endproperty
  a_pause_qe: assert property (p_pause_qe) else $error("pause active with quad enable");

  property p_abandon;
    pif.paused && pif.select_n |=> pif.abandon && !pif.paused ##1 !pif.abandon;
  endproperty
  a_abandon: assert property (p_abandon) else $error("deselect in pause not abandoned");
endmodule // sfb_pause
`default_nettype wire

// ### sim/sfb_host_model.sv
// Host bus master model: mode 0 bus clock, select and lane drive.
// Assumes the bench resolves lane wires from both enable sets.
`timescale 1ns/1ps
`default_nettype none
module sfb_host_model (
  input  wire logic       clk_in,     // Core clock
  input  wire logic [3:0] lane_in,    // Resolved lane levels
  output logic            sclk_out,   // Bus clock
  output logic            sel_n_out,  // Select, active low
  output logic [3:0]      drv_out,    // Lane drive values
  output logic [3:0]      oe_out      // Lane drive enables
);
  initial
  begin
    sclk_out = 1'b0;
    sel_n_out = 1'b1;
    drv_out = 4'hF;
    oe_out = 4'hC;
  end
  task automatic half();
    repeat (4) @(negedge clk_in);
  endtask
  // Pause pin is restored only after select is high again
  task automatic sel(input logic s);
    half();
    sel_n_out = s;
    oe_out = 4'hC;
    half();
    if (s)
      drv_out = 4'hF;
  endtask
  task automatic hold(input logic v);
    half();
    drv_out[3] = v;
    half();
  endtask
  task automatic xfer(input logic [7:0] tx, input int w, input logic dr,
                      output logic [7:0] rx);
    logic [3:0] m;
    m = (w == 4) ? 4'hF : (w == 2) ? 4'h3 : 4'h1;
    oe_out = (w == 1) ? 4'hD : dr ? 4'hF : (w == 2) ? 4'hC : 4'h0;
    rx = 8'h00;
    for (int b = 8 - w; b >= 0; b -= w)
    begin
      drv_out = (drv_out & ~m) | (4'(tx >> b) & m);
      half();
      sclk_out = 1'b1;
      rx = 8'((rx << w) | ((w == 1) ? {3'h0, lane_in[1]} : lane_in & m));
      half();
      sclk_out = 1'b0;
    end
  endtask
endmodule // sfb_host_model
`default_nettype wire

// ### sim/sfb_front_end_bench.sv
// Bench for the front end: reads in every width, modes, pause, clear.
// Assumes lanes idle high through pull-ups when nobody drives them.
`timescale 1ns/1ps
`default_nettype none
module sfb_front_end_bench;
  logic        ref_clk, srst, qe, hclr_n, tx_en, sclk, sel_n, tk, rv, rc, rej, four_wire_command_mode, pz;
  logic [3:0]  drv, moe, lane, lo, loe;
  logic [7:0]  tx_data, rb, b64, last_rx, r;
  logic [23:0] ad;
  logic [11:0] sec;
  int          num_errors, cmp_count, rej_cnt, tk_cnt;
  // Read data stays off the lanes until a read scenario asks for it
  initial
  begin
    {srst, qe, hclr_n, tx_en, tx_data, rej_cnt} = {4'hA, 8'h00, 32'h0};
  end
  assign lane = (loe & lo) | (~loe & moe & drv) | (~loe & ~moe);
  sfb_host_model sfb_host_model_i (.clk_in(ref_clk), .lane_in(lane), .sclk_out(sclk),
    .sel_n_out(sel_n), .drv_out(drv), .oe_out(moe));
  sfb_front_end sfb_front_end_i (.ref_clk_in(ref_clk), .srst_in(srst),
    .bus_clock_in(sclk), .select_n_in(sel_n), .hard_clear_n_in(hclr_n),
    .lane_in(lane), .lane_out(lo), .lane_oe_out(loe), .quad_enable_bit_in(qe),
    .tx_en_in(tx_en), .tx_data_in(tx_data), .tx_take_out(tk), .rx_byte_out(rb),
    .rx_valid_out(rv), .rx_cmd_out(rc), .cmd_reject_out(rej), .qpi_mode_out(four_wire_command_mode),
    .paused_out(pz), .addr_out(ad), .sector_out(sec), .block64_out(b64));
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    if (rv === 1'b1) last_rx <= rb;
    if (rej === 1'b1) rej_cnt <= rej_cnt + 1;
    if (tk === 1'b1) tk_cnt <= tk_cnt + 1;
  end
  // ***
  // Helpers
  // ***
  task automatic chk(input logic [23:0] g, input logic [23:0] e, input string s);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %0t %s", $time, s);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic frame(input logic [7:0] c, input int w);
    sfb_host_model_i.sel(1'b0);
    sfb_host_model_i.xfer(c, w, 1'b1, r);
    sfb_host_model_i.sel(1'b1);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ***
  // Scenarios
  // ***
  task automatic t_read(input logic [7:0] c, input int aw, input int w, input logic [3:0] oe,
                        input logic [7:0] d);
    int tk0;
    tk0 = tk_cnt;
    sfb_host_model_i.sel(1'b0);
    sfb_host_model_i.xfer(c, 1, 1'b1, r);
    sfb_host_model_i.xfer(8'h12, aw, 1'b1, r);
    sfb_host_model_i.xfer(8'h34, aw, 1'b1, r);
    sfb_host_model_i.xfer(8'h56, aw, 1'b1, r);
    // First data bit leaves on the fall that ends the last address bit
    {tx_en, tx_data} = {1'b1, d};
    sfb_host_model_i.xfer(8'h00, w, 1'b0, r);
    chk(r, d, "read data");
    chk(loe, oe, "lane enables");
    chk(ad, 24'h123456, "address");
    chk({sec, b64}, 20'h12312, "sector and block");
    tx_en = 1'b0;
    sfb_host_model_i.sel(1'b1);
    chk(loe, 4'h0, "release");
    chk(tk_cnt - tk0, 1, "one byte taken");
    $display("read %h done", c);
  endtask
  task automatic t_modes();
    qe = 1'b0;
    frame(sfb_pkg::CMD_QUAD_OUT, 1);
    frame(sfb_pkg::CMD_QUAD_IO, 1);
    frame(sfb_pkg::CMD_QPI_ON, 1);
    chk(rej_cnt, 3, "refusals");
    chk(four_wire_command_mode, 1'b0, "mode off");
    qe = 1'b1;
    frame(sfb_pkg::CMD_QPI_ON, 1);
    chk(four_wire_command_mode, 1'b1, "mode on");
    frame(sfb_pkg::CMD_RST_EN, 4);
    chk(last_rx, 8'h66, "nibbles");
    frame(sfb_pkg::CMD_RST, 4);
    chk(four_wire_command_mode, 1'b0, "reset");
    frame(sfb_pkg::CMD_QPI_ON, 1);
    frame(sfb_pkg::CMD_QPI_OFF, 4);
    chk(four_wire_command_mode, 1'b0, "exit");
    frame(sfb_pkg::CMD_QPI_ON, 1);
    chk(four_wire_command_mode, 1'b1, "mode on again");
    hclr_n = 1'b0;
    wt(60);
    hclr_n = 1'b1;
    wt(4);
    chk(four_wire_command_mode, 1'b0, "clear");
    $display("modes done");
  endtask
  task automatic t_pause();
    qe = 1'b0;
    sfb_host_model_i.sel(1'b0);
    sfb_host_model_i.xfer(8'h5A, 1, 1'b1, r);
    sfb_host_model_i.hold(1'b0);
    wt(4);
    chk({pz, loe}, 5'h10, "paused");
    sfb_host_model_i.xfer(8'hFF, 1, 1'b1, r);
    sfb_host_model_i.hold(1'b1);
    wt(4);
    chk(pz, 1'b0, "resumed");
    sfb_host_model_i.xfer(8'hC3, 1, 1'b1, r);
    wt(4);
    chk({last_rx, rc}, 9'h186, "ignored edges");
    sfb_host_model_i.hold(1'b0);
    wt(4);
    sfb_host_model_i.sel(1'b1);
    frame(8'h9C, 1);
    chk({last_rx, rc}, 9'h139, "abandon");
    $display("pause done");
  endtask
  initial
  begin
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk) srst = 1'b0;
    wt(3);
    qe = 1'b1;
    t_read(8'h0B, 1, 1, sfb_pkg::OE_W1, 8'hC3);
    t_read(sfb_pkg::CMD_DUAL_OUT, 1, 2, sfb_pkg::OE_W2, 8'h5A);
    t_read(sfb_pkg::CMD_DUAL_IO, 2, 2, sfb_pkg::OE_W2, 8'hA5);
    t_read(sfb_pkg::CMD_QUAD_OUT, 1, 4, sfb_pkg::OE_W4, 8'h3C);
    t_read(sfb_pkg::CMD_QUAD_IO, 4, 4, sfb_pkg::OE_W4, 8'h96);
    t_modes();
    t_pause();
    wrap_up();
  end
  initial
  begin
    #1000000;
    num_errors++;
    wrap_up();
  end
endmodule // sfb_front_end_bench
`default_nettype wire
